// >>> hw/rss_pkg.sv
// Constants, register map and carrier types of the reset source sequencer.
// Assumes one 125 MHz clock that stands for both the input and reference
// clocks; all figures below are counts of that clock.
package rss_pkg;

   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_STAT    = 8'h04;
   localparam logic [7:0] OFF_SRC     = 8'h08;
   localparam logic [7:0] OFF_CFG_DSI = 8'h0C;
   localparam logic [7:0] OFF_CFG_SYS = 8'h10;

   localparam int CTRL_BMON_EN = 0;
   localparam int CTRL_RDF2    = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;

   localparam int SRC_POR  = 0;
   localparam int SRC_HEXT = 1;
   localparam int SRC_WDOG = 2;
   localparam int SRC_BMON = 3;
   localparam int SRC_SEXT = 4;
   localparam int SRC_TAP  = 5;

   localparam int IPOR_CYC     = 1024;
   localparam int LOCK_REF_CYC = 6400;
   localparam int HRST_CYC     = 512;
   localparam int SRST_CYC     = 515;
   localparam int SOFT_CYC     = 3;

   // Built-in word for configuration slaves; the value is arbitrary.
   localparam logic [31:0] CFG_DEFAULT = 32'h0000_0000;
   localparam logic [31:0] CFG_RST     = 32'h0000_0000;

   typedef struct packed {
      logic       config_mode_select;
      logic       config_role_select;
      logic       host_if_sync_select;
      logic       host_if_wide_select;
      logic [3:0] chip_identifier;
      logic [2:0] boot_mode;
      logic       watchdog_enable_strap;
      logic [1:0] clock_mode_strap;
   } rss_strap_t;

   typedef struct packed {
      logic peripheral_bus;
      logic cores;
      logic multicore_bus;
      logic system_interface_unit;
      logic system_pll;
   } rss_domain_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rss_apb_t;

   typedef enum logic [6:0] {
      S_POR  = 7'b000_0001,
      S_IPOR = 7'b000_0010,
      S_PLL  = 7'b000_0100,
      S_HRST = 7'b000_1000,
      S_SRST = 7'b001_0000,
      S_SOFT = 7'b010_0000,
      S_RUN  = 7'b100_0000
   } rss_state_t;

endpackage

// >>> hw/rss_sequencer.sv
// Reset source sequencer: collects reset requests, sequences release and
// holds the captured straps and the reset configuration word.
// Assumes board pins arrive asynchronously and watchdog, bus-monitor and
// boundary-scan requests come as one-cycle pulses on clk.
//
// Overview of operation
// - Power-on alone samples straps, resets PLL, DSI write
// - Power-on and hard: drive hard pin, reset SYSTEM_INTERFACE_UNIT
// - Every source resets peripherals, cores, multicore bus
// - Internal power-on stays 1024 cycles after release
// - PLL locks 6400 reference cycles later, 12800 with RDF2 set
// - Hard output released 512 cycles after lock
// - Soft output released 515 cycles after lock
// - Fourteen straps captured at power-on release
// - Config word written by DSI or system bus
// - Slave role, nothing written: apply default word
// - External soft request seen only when idle
// - Soft reset asserted whenever hard reset is
// - Enabled watchdog or monitor expiry starts hard reset
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module rss_sequencer #(
   parameter int LOCK_REF = rss_pkg::LOCK_REF_CYC
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               power_on_reset_n,
   input  wire logic               hard_reset_n_in,
   output      logic               hard_reset_n_out,
   output      logic               hard_reset_n_oe,
   input  wire logic               soft_reset_n_in,
   output      logic               soft_reset_n_out,
   output      logic               soft_reset_n_oe,
   input  wire rss_pkg::rss_strap_t strap,
   input  wire logic               watchdog_expired,
   input  wire logic               bus_monitor_expired,
   input  wire logic               tap_soft_cmd,
   input  wire logic               tap_drive_soft,
   input  wire rss_pkg::rss_apb_t   apb,
   output      logic [31:0]        prdata,
   output      logic               pready,
   output      logic               pslverr,
   output      rss_pkg::rss_domain_t domain_reset,
   output      rss_pkg::rss_strap_t  strap_q,
   output      logic [31:0]        config_word
);

   // Pin synchronisers; stage one feeds only stage two.
   logic               por_m, por_s, hrd_m, hrd_s, hrd_d;
   logic               sft_m, sft_s, sft_d;
   rss_pkg::rss_strap_t str_m, str_s;

   always_ff @(posedge clk) begin
      if (srst) begin
         por_m <= 1'b0;
         por_s <= 1'b0;
         hrd_m <= 1'b1;
         hrd_s <= 1'b1;
         hrd_d <= 1'b1;
         sft_m <= 1'b1;
         sft_s <= 1'b1;
         sft_d <= 1'b1;
      end else begin
         por_m <= power_on_reset_n;
         por_s <= por_m;
         hrd_m <= hard_reset_n_in;
         hrd_s <= hrd_m;
         hrd_d <= hrd_s;
         sft_m <= soft_reset_n_in;
         sft_s <= sft_m;
         sft_d <= sft_s;
      end
      str_m <= strap;
      str_s <= str_m;
   end

   rss_pkg::rss_state_t state, next_state;
   logic [13:0]         cnt, next_cnt, lock_cyc;
   logic                soft_drive, next_soft_drive;
   logic                bmon_en, next_bmon_en, rdf2, next_rdf2;
   logic [5:0]          src, next_src;
   logic                kind_por, next_kind_por;
   logic                kind_hard, next_kind_hard;
   logic                cfg_wr, next_cfg_wr;
   logic [31:0]         next_config_word, next_prdata;
   rss_pkg::rss_strap_t next_strap_q;
   rss_pkg::rss_domain_t next_domain;
   logic                idle, hard_evt, soft_evt, tap_evt;
   logic                wr, rd, wr_dsi, wr_sys;

   assign idle     = state == rss_pkg::S_RUN;
   assign lock_cyc = rdf2 ? 14'(2 * LOCK_REF) : 14'(LOCK_REF);
   assign hard_evt = (idle || state == rss_pkg::S_SOFT)
                     && ((hrd_d && !hrd_s)
                         || (watchdog_expired
                             && strap_q.watchdog_enable_strap)
                         || (bus_monitor_expired && bmon_en));
   assign soft_evt = idle && sft_d && !sft_s;
   assign tap_evt  = idle && tap_soft_cmd;

   // Sequencer.
   always_comb begin
      next_state      = state;
      next_cnt        = cnt + 14'd1;
      next_soft_drive = soft_drive;
      unique case (state)
         rss_pkg::S_POR: next_cnt = 14'd0;
         rss_pkg::S_IPOR:
            if (cnt == 14'(rss_pkg::IPOR_CYC - 1)) begin
               next_state = rss_pkg::S_PLL;
               next_cnt   = 14'd0;
            end
         rss_pkg::S_PLL:
            if (cnt == lock_cyc - 14'd1) begin
               next_state = rss_pkg::S_HRST;
               next_cnt   = 14'd0;
            end
         rss_pkg::S_HRST:
            if (cnt == 14'(rss_pkg::HRST_CYC - 1)) begin
               next_state = rss_pkg::S_SRST;
            end
         rss_pkg::S_SRST:
            if (cnt == 14'(rss_pkg::SRST_CYC - 1)) begin
               next_state = rss_pkg::S_RUN;
               next_cnt   = 14'd0;
            end
         rss_pkg::S_SOFT:
            if (cnt == 14'(rss_pkg::SOFT_CYC - 1)) begin
               next_state = rss_pkg::S_RUN;
            end
         rss_pkg::S_RUN: next_cnt = 14'd0;
         default: begin
            next_state = rss_pkg::S_POR;
            next_cnt   = 14'd0;
         end
      endcase
      if (hard_evt) begin
         next_state = rss_pkg::S_HRST;
         next_cnt   = 14'd0;
      end else if (soft_evt || tap_evt) begin
         next_state      = rss_pkg::S_SOFT;
         next_cnt        = 14'd0;
         next_soft_drive = soft_evt || tap_drive_soft;
      end
      if (state == rss_pkg::S_POR && por_s) begin
         next_state = rss_pkg::S_IPOR;
      end
      if (!por_s) begin
         next_state = rss_pkg::S_POR;
      end
   end

   // Reset domains follow the next state so the outputs are registered.
   always_comb begin
      next_domain.system_pll            = next_state == rss_pkg::S_POR
                                        || next_state == rss_pkg::S_IPOR;
      next_domain.system_interface_unit = next_domain.system_pll
                                        || next_state == rss_pkg::S_PLL
                                        || next_state == rss_pkg::S_HRST;
      next_domain.peripheral_bus        = next_state != rss_pkg::S_RUN;
      next_domain.cores                 = next_state != rss_pkg::S_RUN;
      next_domain.multicore_bus         = next_state != rss_pkg::S_RUN;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state        <= rss_pkg::S_POR;
         cnt          <= 14'd0;
         soft_drive   <= 1'b0;
         domain_reset <= '1;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         soft_drive   <= next_soft_drive;
         domain_reset <= next_domain;
      end
   end

   // Open-drain pins only ever pull low.
   assign hard_reset_n_out = 1'b0;
   assign soft_reset_n_out = 1'b0;
   assign hard_reset_n_oe  = domain_reset.system_interface_unit;
   assign soft_reset_n_oe  = hard_reset_n_oe
                             || state == rss_pkg::S_SRST
                             || (state == rss_pkg::S_SOFT && soft_drive);

   // Register bus and configuration state.
   assign wr     = apb.psel && apb.penable && apb.pwrite;
   assign rd     = apb.psel && !apb.penable && !apb.pwrite;
   assign wr_dsi = wr && apb.paddr == rss_pkg::OFF_CFG_DSI
                   && kind_por && !idle;
   assign wr_sys = wr && apb.paddr == rss_pkg::OFF_CFG_SYS
                   && kind_hard && !idle;
   assign pready = 1'b1;
   always_comb begin
      unique case (apb.paddr)
         rss_pkg::OFF_CTRL, rss_pkg::OFF_STAT, rss_pkg::OFF_SRC,
         rss_pkg::OFF_CFG_DSI, rss_pkg::OFF_CFG_SYS: pslverr = 1'b0;
         default: pslverr = apb.psel && apb.penable;
      endcase
   end

   always_comb begin
      next_bmon_en     = bmon_en;
      next_rdf2        = rdf2;
      next_src         = src;
      next_kind_por    = kind_por;
      next_kind_hard   = kind_hard;
      next_cfg_wr      = cfg_wr;
      next_config_word = config_word;
      next_strap_q     = strap_q;
      next_prdata      = prdata;
      if (wr && apb.paddr == rss_pkg::OFF_CTRL) begin
         next_bmon_en = apb.pwdata[rss_pkg::CTRL_BMON_EN];
         next_rdf2    = apb.pwdata[rss_pkg::CTRL_RDF2];
      end
      // Clear first so that a same-cycle event still sets its bit.
      if (wr && apb.paddr == rss_pkg::OFF_SRC) begin
         next_src = src & ~apb.pwdata[5:0];
      end
      if (wr_dsi || wr_sys) begin
         next_config_word = apb.pwdata;
         next_cfg_wr      = 1'b1;
      end
      if (state == rss_pkg::S_HRST
          && next_state == rss_pkg::S_SRST
          && strap_q.config_role_select && !cfg_wr) begin
         next_config_word = rss_pkg::CFG_DEFAULT;
      end
      if (hard_evt) begin
         next_kind_hard = 1'b1;
         next_cfg_wr    = 1'b0;
         next_src[rss_pkg::SRC_HEXT] = next_src[rss_pkg::SRC_HEXT]
                                       | (hrd_d && !hrd_s);
         next_src[rss_pkg::SRC_WDOG] = next_src[rss_pkg::SRC_WDOG]
                                       | watchdog_expired;
         next_src[rss_pkg::SRC_BMON] = next_src[rss_pkg::SRC_BMON]
                                       | bus_monitor_expired;
      end else begin
         next_src[rss_pkg::SRC_SEXT] = next_src[rss_pkg::SRC_SEXT]
                                       | soft_evt;
         next_src[rss_pkg::SRC_TAP]  = next_src[rss_pkg::SRC_TAP]
                                       | (tap_evt && !soft_evt);
      end
      if (state == rss_pkg::S_POR) begin
         next_kind_por  = 1'b1;
         next_kind_hard = 1'b1;
         next_cfg_wr    = 1'b0;
         if (por_s) begin
            next_strap_q = str_s;
            next_src[rss_pkg::SRC_POR] = 1'b1;
         end
      end
      if (next_state == rss_pkg::S_RUN) begin
         next_kind_por  = 1'b0;
         next_kind_hard = 1'b0;
      end
      if (rd) begin
         unique case (apb.paddr)
            rss_pkg::OFF_CTRL:    next_prdata = {30'h0, rdf2, bmon_en};
            rss_pkg::OFF_STAT:    next_prdata = {11'h0, state, strap_q};
            rss_pkg::OFF_SRC:     next_prdata = {26'h0, src};
            rss_pkg::OFF_CFG_DSI,
            rss_pkg::OFF_CFG_SYS: next_prdata = config_word;
            default:              next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bmon_en     <= rss_pkg::CTRL_RST[rss_pkg::CTRL_BMON_EN];
         rdf2        <= rss_pkg::CTRL_RST[rss_pkg::CTRL_RDF2];
         src         <= 6'h00;
         kind_por    <= 1'b1;
         kind_hard   <= 1'b1;
         cfg_wr      <= 1'b0;
         config_word <= rss_pkg::CFG_RST;
         strap_q     <= '0;
         prdata      <= 32'h0000_0000;
      end else begin
         bmon_en     <= next_bmon_en;
         rdf2        <= next_rdf2;
         src         <= next_src;
         kind_por    <= next_kind_por;
         kind_hard   <= next_kind_hard;
         cfg_wr      <= next_cfg_wr;
         config_word <= next_config_word;
         strap_q     <= next_strap_q;
         prdata      <= next_prdata;
      end
   end

   chk_soft_with_hard: assert property (@(posedge clk) disable iff (srst)
      hard_reset_n_oe |-> soft_reset_n_oe)
      else $error("hard reset driven without soft reset");
   chk_ipor_release: assert property (@(posedge clk) disable iff (srst)
      state == rss_pkg::S_IPOR && cnt == 14'(rss_pkg::IPOR_CYC - 1) && por_s
      |=> state == rss_pkg::S_PLL ##1 domain_reset.system_pll == 1'b0)
      else $error("internal power-on not released after 1024 cycles");
   chk_pll_lock: assert property (@(posedge clk) disable iff (srst)
      state == rss_pkg::S_PLL && cnt < lock_cyc - 14'd1 && por_s
      |=> state == rss_pkg::S_PLL)
      else $error("lock step left early");
   chk_hard_release: assert property (@(posedge clk) disable iff (srst)
      state == rss_pkg::S_HRST && cnt == 14'(rss_pkg::HRST_CYC - 1) && por_s
      |=> !hard_reset_n_oe && soft_reset_n_oe)
      else $error("hard reset not released at 512");
   chk_soft_release: assert property (@(posedge clk) disable iff (srst)
      state == rss_pkg::S_SRST && por_s && !hard_evt
      ##1 state == rss_pkg::S_SRST ##1 state == rss_pkg::S_SRST
      |=> !soft_reset_n_oe && cnt == 14'd0)
      else $error("soft reset not released three cycles after hard");
   chk_strap_capture: assert property (@(posedge clk) disable iff (srst)
      state == rss_pkg::S_POR && por_s |=> strap_q == $past(str_s))
      else $error("straps not captured at power-on release");
   chk_dsi_gate: assert property (@(posedge clk) disable iff (srst)
      wr && apb.paddr == rss_pkg::OFF_CFG_DSI && !kind_por
      |=> config_word == $past(config_word))
      else $error("DSI configuration write outside power-on");
   chk_soft_scope: assert property (@(posedge clk) disable iff (srst)
      state == rss_pkg::S_SOFT |-> !domain_reset.system_interface_unit
      && !domain_reset.system_pll && domain_reset.cores)
      else $error("soft reset touched hard-only domains");
   chk_watchdog: assert property (@(posedge clk) disable iff (srst)
      idle && watchdog_expired && strap_q.watchdog_enable_strap && por_s
      |=> state == rss_pkg::S_HRST ##1 hard_reset_n_oe)
      else $error("watchdog expiry did not start hard reset");
   chk_ext_soft: assert property (@(posedge clk) disable iff (srst)
      !idle && state != rss_pkg::S_SOFT |=> state != rss_pkg::S_SOFT)
      else $error("soft request taken while asserting reset");

endmodule // rss_sequencer

// >>> sim/rss_board.sv
// Board model: power-on pin, open-drain reset pins and strap pins.
// Assumes pull-ups on both reset pins and a clock shared with the chip.
`timescale 1ns/1ps
module rss_board (
   input  wire logic                clk,
   input  wire logic                hard_oe,
   input  wire logic                soft_oe,
   output      logic                por_n,
   output      logic                hard_n,
   output      logic                soft_n,
   output      rss_pkg::rss_strap_t strap
);
   logic pull_soft = 1'b0;
   logic pull_hard = 1'b0;
   initial por_n = 1'b0;
   initial strap = '0;
   // A released pin reads high through its pull-up.
   assign hard_n = !(hard_oe || pull_hard);
   assign soft_n = !(soft_oe || pull_soft);
   task automatic power_on(input rss_pkg::rss_strap_t s, input int n);
      strap <= s;
      por_n <= 1'b0;
      repeat ((n < 16) ? 16 : n) @(posedge clk);
      por_n <= 1'b1;
      fork
         begin
            // Past the hold time the pins show something else.
            repeat (8) @(posedge clk);
            strap <= ~s;
         end
      join_none
   endtask
   task automatic press_hard(input int n);
      pull_hard <= 1'b1;
      repeat (n) @(posedge clk);
      pull_hard <= 1'b0;
   endtask
   task automatic press_soft(input int n);
      pull_soft <= 1'b1;
      repeat (n) @(posedge clk);
      pull_soft <= 1'b0;
   endtask
endmodule // rss_board

// >>> sim/rss_sequencer_test.sv
// Self-checking bench of the reset source sequencer beside a board model.
// Assumes one 125 MHz clock and a shortened PLL lock count.
`timescale 1ns/1ps
module rss_sequencer_test;
   localparam int LOCK = 16;
   logic                 clk = 1'b0;
   logic                 srst = 1'b1;
   logic                 wdog = 1'b0;
   logic                 bmon = 1'b0;
   logic                 tap_cmd = 1'b0;
   logic                 tap_drv = 1'b0;
   logic                 por_n, hard_n, soft_n, hard_oe, soft_oe;
   logic                 hard_o, soft_o, pready, pslverr;
   rss_pkg::rss_strap_t  strap, strap_q;
   rss_pkg::rss_apb_t    apb = '0;
   rss_pkg::rss_domain_t dom;
   logic [31:0]          prdata, config_word, exp_cfg;
   logic [31:0]          rnd = 32'h0000_ff32;
   int                   n_errors = 0;
   int                   n_checks = 0;

   always #4 clk = !clk;

   rss_sequencer #(.LOCK_REF(LOCK)) i_rss_sequencer (
      .clk(clk), .srst(srst), .power_on_reset_n(por_n),
      .hard_reset_n_in(hard_n), .hard_reset_n_out(hard_o),
      .hard_reset_n_oe(hard_oe), .soft_reset_n_in(soft_n),
      .soft_reset_n_out(soft_o), .soft_reset_n_oe(soft_oe),
      .strap(strap), .watchdog_expired(wdog),
      .bus_monitor_expired(bmon), .tap_soft_cmd(tap_cmd),
      .tap_drive_soft(tap_drv), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .domain_reset(dom),
      .strap_q(strap_q), .config_word(config_word));

   rss_board i_rss_board (.clk(clk), .hard_oe(hard_oe), .soft_oe(soft_oe),
      .por_n(por_n), .hard_n(hard_n), .soft_n(soft_n), .strap(strap));

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic apb_xfer(input logic wr, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] rd,
                           output logic err);
      @(posedge clk);
      apb <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      apb.penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apb <= '0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      logic [31:0] d;
      logic        err;
      apb_xfer(1'b1, a, w, d, err);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic e_err);
      logic [31:0] d;
      logic        err;
      apb_xfer(1'b0, a, '0, d, err);
      check({err, d}, {e_err, e});
   endtask

   // Counts the cycles each reset output stands, once the sequence shows.
   task automatic measure(input logic go, output int nh, output int ns,
                          output logic [4:0] dor, output logic bad);
      int k;
      k = 0;
      nh = 0;
      ns = 0;
      dor = '0;
      bad = 1'b0;
      while (go && !(soft_oe || dom != '0) && k < 40) begin
         @(posedge clk);
         #1;
         k++;
      end
      do begin
         @(posedge clk);
         nh += int'(hard_oe);
         ns += int'(soft_oe);
         dor |= dom;
         bad |= hard_oe && !soft_oe;
      end while (hard_oe || soft_oe || dom != '0);
   endtask

   task automatic kick(input int k);
      if (k == 3) begin
         i_rss_board.press_soft(2);
      end else if (k == 4) begin
         i_rss_board.press_hard(2);
      end else begin
         @(posedge clk);
         {tap_cmd, bmon, wdog} <= 3'b001 << k;
         @(posedge clk);
         {tap_cmd, bmon, wdog} <= 3'b000;
      end
   endtask

   // Kinds: 0 watchdog, 1 bus monitor, 2 boundary scan, 3 soft pin,
   // 4 hard pin with no configuration write, so the default word applies.
   task automatic run_seq(input int k, input int e_nh, input int e_ns,
                          input logic [4:0] e_dom, input logic [31:0] e_src);
      int          nh, ns;
      logic [4:0]  dor;
      logic        bad;
      logic [31:0] w;
      rnd = lfsr(rnd);
      w = rnd;
      if (k == 4) begin
         exp_cfg = rss_pkg::CFG_DEFAULT;
      end
      fork
         kick(k);
         measure(1'b1, nh, ns, dor, bad);
         if (e_nh != 0 && k != 4) begin
            repeat (30) @(posedge clk);
            i_rss_board.press_soft(20);
            wr(rss_pkg::OFF_CFG_SYS, w);
            wr(rss_pkg::OFF_CFG_DSI, ~w);
            exp_cfg = w;
         end
      join
      check(nh, e_nh);
      check(ns, e_ns);
      check(dor, e_dom);
      check(bad, 1'b0);
      check(config_word, exp_cfg);
      rd_chk(rss_pkg::OFF_SRC, e_src, 1'b0);
      wr(rss_pkg::OFF_SRC, 32'h0000_003f);
      rd_chk(rss_pkg::OFF_SRC, 32'h0000_0000, 1'b0);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end

   initial begin
      rss_pkg::rss_strap_t s;
      int                  nh, ns, lo;
      logic [4:0]          dor;
      logic                bad;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rnd = lfsr(rnd);
      s = rnd[13:0];
      s.watchdog_enable_strap = 1'b1;
      s.config_role_select    = 1'b1;
      rnd = lfsr(rnd);
      exp_cfg = rnd;
      i_rss_board.power_on(s, 20);
      fork
         measure(1'b0, nh, ns, dor, bad);
         begin
            repeat (100) @(posedge clk);
            wr(rss_pkg::OFF_CFG_DSI, exp_cfg);
         end
      join
      // Pin synchroniser latency leaves a few cycles of slack here.
      lo = rss_pkg::IPOR_CYC + LOCK + rss_pkg::HRST_CYC;
      check(nh >= lo && nh <= lo + 6, 1'b1);
      check(ns - nh, rss_pkg::SRST_CYC - rss_pkg::HRST_CYC);
      check(dor, 5'h1f);
      check(bad, 1'b0);
      check(strap_q, s);
      rd_chk(rss_pkg::OFF_STAT, {11'h000, 7'h40, s}, 1'b0);
      rd_chk(rss_pkg::OFF_CFG_DSI, exp_cfg, 1'b0);
      wr(rss_pkg::OFF_CFG_DSI, ~exp_cfg);
      wr(rss_pkg::OFF_CFG_SYS, ~exp_cfg);
      rd_chk(rss_pkg::OFF_CFG_SYS, exp_cfg, 1'b0);
      rd_chk(8'h14, 32'h0000_0000, 1'b1);
      run_seq(0, rss_pkg::HRST_CYC, rss_pkg::SRST_CYC, 5'h1e,
              32'h0000_0005);
      run_seq(3, 0, rss_pkg::SOFT_CYC, 5'h1c, 32'h0000_0010);
      tap_drv <= 1'b0;
      run_seq(2, 0, 0, 5'h1c, 32'h0000_0020);
      tap_drv <= 1'b1;
      run_seq(2, 0, rss_pkg::SOFT_CYC, 5'h1c, 32'h0000_0020);
      run_seq(1, 0, 0, 5'h00, 32'h0000_0000);
      wr(rss_pkg::OFF_CTRL, 32'h0000_0001);
      run_seq(1, rss_pkg::HRST_CYC, rss_pkg::SRST_CYC, 5'h1e,
              32'h0000_0008);
      run_seq(4, rss_pkg::HRST_CYC, rss_pkg::SRST_CYC, 5'h1e,
              32'h0000_0002);
      finish_test();
   end
endmodule // rss_sequencer_test
